// ===== design/tsc_defs.svh
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// Register byte addresses on the plain register port
`define TSC_ADDR_CTRL 8'hd2
`define TSC_ADDR_RES_LO 8'hca
`define TSC_ADDR_RES_HI 8'hcb
`define TSC_ADDR_IRQ_STAT 8'h10
`define TSC_ADDR_IRQ_EN 8'h11
`define TSC_ADDR_IRQ_CLR 8'h12

// Control register fields and reset value
`define TSC_BIT_START 7
`define TSC_BIT_DONE 6
`define TSC_LEN_MSB 2
`define TSC_LEN_LSB 0
`define TSC_CTRL_RESET 8'h00

// Interrupt status bit positions and reset values
`define TSC_IRQ_DONE 0
`define TSC_IRQ_IGNORED 1
`define TSC_IRQ_RESET 2'h0

// Conversion timing: 256 sensor periods per unit, plus a fixed settle time
`define TSC_PERIOD_SHIFT 8
`define TSC_SETTLE_US 32
`define TSC_CLK_MHZ 100
`define TSC_SETTLE_CYCLES (`TSC_SETTLE_US * `TSC_CLK_MHZ)

`endif

// ===== design/tsc_pkg.sv
package tsc_pkg;

	// One access from the register master
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tsc_bus_req_t;

	typedef enum logic [1:0] {
		TSC_IDLE,
		TSC_COUNT,
		TSC_SETTLE
	} tsc_phase_t;

	// Conversion timer state
	typedef struct packed {
		tsc_phase_t phase;
		logic [16:0] periods;
		logic [16:0] target;
		logic [11:0] settle;
		logic sclk_prev;
		logic done;
	} tsc_tmr_state_t;

	// Register block state
	typedef struct packed {
		logic start;
		logic done_flag;
		logic [2:0] len;
		logic [15:0] result;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic [7:0] rdata;
	} tsc_state_t;

endpackage

// ===== design/tsc_timer.sv
`timescale 1ns/1ns
`include "tsc_defs.svh"

module tsc_timer
	import tsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic [2:0] len,
	input wire logic sensor_clk,
	output logic busy,
	output logic done
);

	tsc_tmr_state_t s;
	tsc_tmr_state_t next_s;
	logic sclk_rise;
	logic [8:0] units;

	// Sensor clock is sampled as a plain synchronous input
	assign sclk_rise = sensor_clk & ~s.sclk_prev;
	// 2^(len+1)+1 units of 256 periods; shifting a two keeps length 7 from wrapping
	assign units = (9'h002 << len) + 9'h001;

	// Count sensor periods, then the fixed settle time
	always_comb begin
		next_s = s;
		next_s.sclk_prev = sensor_clk;
		next_s.done = 1'b0;
		unique case (s.phase)
			TSC_IDLE: begin
				if (start) begin
					next_s.phase = TSC_COUNT;
					next_s.periods = 17'h00000;
					next_s.target = {units, 8'h00};
				end
			end
			TSC_COUNT: begin
				if (sclk_rise) begin
					next_s.periods = s.periods + 17'h00001;
					if (s.periods == s.target - 17'h00001) begin
						next_s.phase = TSC_SETTLE;
						next_s.settle = 12'h000;
					end
				end
			end
			TSC_SETTLE: begin
				next_s.settle = s.settle + 12'h001;
				// Done cycle is the last settle cycle, so the flag lands 32 us after the count
				if (s.settle == 12'(`TSC_SETTLE_CYCLES - 2)) begin
					next_s.phase = TSC_IDLE;
					next_s.done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '{phase: TSC_IDLE, periods: 17'h00000, target: 17'h00000,
				settle: 12'h000, sclk_prev: 1'b0, done: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// Busy spans the done cycle, so the front end still drives its result at capture
	assign busy = (s.phase != TSC_IDLE) || s.done;
	assign done = s.done;

endmodule

// ===== design/tsc_top.sv
`timescale 1ns/1ns
`include "tsc_defs.svh"

module tsc_top
	import tsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire tsc_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire logic sensor_clk,
	input wire logic [15:0] sensor_value,
	output logic sensor_enable,
	output logic irq
);

	tsc_state_t s;
	tsc_state_t next_s;
	logic tmr_busy;
	logic tmr_done;
	logic wr_ctrl;
	logic start_seq;
	logic start_go;
	logic start_ignored;
	logic [1:0] irq_events;
	logic [1:0] irq_clear;
	logic [7:0] ctrl_view;

	// Register access decode
	assign wr_ctrl = bus_req.wr && (bus_req.addr == `TSC_ADDR_CTRL);

	// Falling start bit, written by software, completes the sequence
	assign start_seq = wr_ctrl && s.start && !bus_req.wdata[`TSC_BIT_START];

	// A sequence while a conversion runs is dropped and reported
	assign start_go = start_seq && !tmr_busy;
	assign start_ignored = start_seq && tmr_busy;

	// Events feeding the sticky status bits
	always_comb begin
		irq_events = 2'h0;
		irq_events[`TSC_IRQ_DONE] = tmr_done;
		irq_events[`TSC_IRQ_IGNORED] = start_ignored;
	end

	// Write-one-to-clear mask from the clear register
	assign irq_clear = (bus_req.wr && (bus_req.addr == `TSC_ADDR_IRQ_CLR)) ? bus_req.wdata[1:0] : 2'h0;

	// Control register as software sees it; reserved bits read zero
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[`TSC_BIT_START] = s.start;
		ctrl_view[`TSC_BIT_DONE] = s.done_flag;
		ctrl_view[`TSC_LEN_MSB:`TSC_LEN_LSB] = s.len;
	end

	// Next state of the register block
	always_comb begin
		next_s = s;

		// Control writes: start bit and length are software fields
		if (wr_ctrl) begin
			next_s.start = bus_req.wdata[`TSC_BIT_START];
			next_s.len = bus_req.wdata[`TSC_LEN_MSB:`TSC_LEN_LSB];
			// Writing one to the flag does nothing; only zero clears it
			if (!bus_req.wdata[`TSC_BIT_DONE]) begin
				next_s.done_flag = 1'b0;
			end
		end

		// Result lands on the same edge as the flag, so reads are never stale
		if (tmr_done) begin
			next_s.result = sensor_value;
			next_s.done_flag = 1'b1;
		end

		// Interrupt enable register
		if (bus_req.wr && (bus_req.addr == `TSC_ADDR_IRQ_EN)) begin
			next_s.irq_en = bus_req.wdata[1:0];
		end

		// Sticky status: a new event beats a clear in the same cycle
		next_s.irq_stat = (s.irq_stat & ~irq_clear) | irq_events;

		// Read data registered, valid only in the cycle after the strobe
		next_s.rdata = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`TSC_ADDR_CTRL: next_s.rdata = ctrl_view;
				`TSC_ADDR_RES_LO: next_s.rdata = s.result[7:0];
				`TSC_ADDR_RES_HI: next_s.rdata = s.result[15:8];
				`TSC_ADDR_IRQ_STAT: next_s.rdata = {6'h00, s.irq_stat};
				`TSC_ADDR_IRQ_EN: next_s.rdata = {6'h00, s.irq_en};
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	// Register update
	always_ff @(posedge clock) begin
		if (rst) begin
			s <= '{start: 1'b0, done_flag: 1'b0, len: 3'h0, result: 16'h0000,
				irq_stat: `TSC_IRQ_RESET, irq_en: `TSC_IRQ_RESET, rdata: 8'h00};
		end else begin
			s <= next_s;
		end
	end

	// Conversion timer; it latches the length at start
	tsc_timer u_timer (
		.clock(clock),
		.rst(rst),
		.start(start_go),
		.len(s.len),
		.sensor_clk(sensor_clk),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// Front end powered only while a conversion runs
	assign sensor_enable = tmr_busy;
	assign bus_rdata = s.rdata;
	// Level interrupt while any enabled status bit stands
	assign irq = |(s.irq_stat & s.irq_en);

endmodule

// ===== verif/tsc_monitor.sv
`timescale 1ns/1ns
module tsc_monitor
	import tsc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire tsc_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata,
	input wire logic sensor_clk,
	input wire logic sensor_enable,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic arm, en0, fin, en_q;
	logic [2:0] len;
	logic [16:0] rises;
	logic [12:0] wait_n;
	wire ctl = bus_req.wr && bus_req.addr == 8'hd2;
	wire rel = ctl && !bus_req.wdata[7] && arm;
	wire [16:0] need = {(9'h2 << len) + 9'h1, 8'h00};
	// Flag as software sees it: the edge that drops the enable also sets it
	wire fin_now = fin | (en_q & ~sensor_enable);
	// Shadow of writes and of conversion progress
	always_ff @(posedge clock) begin
		if (rst) begin
			{arm, en0, fin, en_q, len, rises, wait_n} <= '0;
		end else begin
			if (ctl) {arm, len} <= {bus_req.wdata[7], bus_req.wdata[2:0]};
			if (bus_req.wr && bus_req.addr == 8'h11) en0 <= bus_req.wdata[0];
			// Clear first, as the set is seen a cycle late
			fin <= ctl && !bus_req.wdata[6] ? 1'b0 : fin | $fell(sensor_enable);
			rises <= sensor_enable ? rises + 17'($rose(sensor_clk)) : '0;
			wait_n <= sensor_enable && rises >= need ? wait_n + 13'h1 : '0;
			en_q <= sensor_enable;
		end
	end
	sequence s_ctl_read;
		bus_req.rd && bus_req.addr == 8'hd2;
	endsequence
	AST_START: assert property ($rose(sensor_enable) |-> $past(rel) || $past(rel, 2))
		else $error("start without arm");
	AST_TIME: assert property ($fell(sensor_enable) |-> wait_n == 13'hc80)
		else $error("bad length");
	AST_DONE: assert property (s_ctl_read |=> bus_rdata[6] == $past(fin_now))
		else $error("bad done flag");
	AST_IRQ_SET: assert property ($fell(sensor_enable) && en0 |-> irq)
		else $error("no irq");
	AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(bus_req.wr))
		else $error("irq dropped");
	AST_RDATA: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
		else $error("stray read data");
endmodule
bind tsc_top tsc_monitor tsc_monitor_inst (.clock, .rst, .bus_req, .bus_rdata, .sensor_clk, .sensor_enable, .irq);

// ===== verif/tsc_front.sv
`timescale 1ns/1ns
module tsc_front #(
	parameter logic [15:0] RESULT = 16'h0000
) (
	input wire logic clock,
	input wire logic sensor_enable,
	output logic sensor_clk,
	output logic [15:0] sensor_value
);
	// Clock runs only while converting
	always_ff @(posedge clock) begin
		sensor_clk <= sensor_enable & ~sensor_clk;
	end
	// Inverted when idle, so a late capture shows
	assign sensor_value = sensor_enable ? RESULT : ~RESULT;
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ns
module tb
	import tsc_pkg::*;
;
	logic clock, rst, sensor_clk, sensor_enable, irq;
	logic [7:0] bus_rdata;
	logic [15:0] sensor_value;
	tsc_bus_req_t bus_req;
	int num_errors, compares, cyc;
	// Rows: write flag, address, data or expected read
	logic [19:0] rows [13] = '{20'h0d200, 20'h0ca00, 20'h01000, 20'h1d247, 20'h0d207, 20'h11103, 20'h01103,
		20'h01200, 20'h05500, 20'h1ca12, 20'h0ca00, 20'h110ff, 20'h01000};
	tsc_top tsc_top_inst (.clock, .rst, .bus_req, .bus_rdata, .sensor_clk, .sensor_value, .sensor_enable, .irq);
	tsc_front #(.RESULT(16'hbeef)) tsc_front_inst (.clock, .sensor_enable, .sensor_clk, .sensor_value);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t %h %h", $time, s, e);
		end
	endtask
	// Idle cycle after each strobe keeps drives apart
	task automatic acc(input logic w, input logic [7:0] a, d);
		bus_req <= '{a, w ? d : 8'h00, w, !w};
		@(posedge clock);
		bus_req <= '0;
		#1;
		if (!w) chk(bus_rdata, d);
		@(posedge clock);
	endtask
	task automatic wait_irq;
		for (int k = 0; k < 9000 && irq !== 1'b1; k++) @(negedge clock);
		// A conversion that never ends counts against the run
		if (irq !== 1'b1) num_errors++;
		@(posedge clock);
	endtask
	task automatic give_verdict;
		$display("errors %0d of %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Ceiling well above the 11000 cycles needed
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		rst = 1'b1;
		bus_req = '0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		foreach (rows[i]) acc(rows[i][16], rows[i][15:8], rows[i][7:0]);
		$display("regs end");
		acc(1'b1, 8'hd2, 8'h80);
		acc(1'b1, 8'hd2, 8'h00);
		wait_irq();
		chk(8'({sensor_enable, irq}), 8'h01);
		acc(1'b0, 8'hca, 8'hef);
		acc(1'b0, 8'hcb, 8'hbe);
		acc(1'b0, 8'hd2, 8'h40);
		acc(1'b0, 8'hd2, 8'h40);
		acc(1'b0, 8'h10, 8'h01);
		acc(1'b1, 8'h12, 8'h03);
		chk(8'(irq), 8'h00);
		$display("run 0 end");
		// Restart while busy must be ignored
		acc(1'b1, 8'h11, 8'h01);
		acc(1'b1, 8'hd2, 8'h81);
		acc(1'b0, 8'hd2, 8'h81);
		acc(1'b1, 8'hd2, 8'h01);
		acc(1'b1, 8'hd2, 8'h81);
		acc(1'b1, 8'hd2, 8'h01);
		wait_irq();
		acc(1'b0, 8'h10, 8'h03);
		acc(1'b0, 8'hd2, 8'h41);
		$display("run 1 end");
		// Reset in mid-conversion returns every register to zero
		acc(1'b1, 8'hd2, 8'h80);
		acc(1'b1, 8'hd2, 8'h00);
		repeat (20) @(posedge clock);
		chk(8'(sensor_enable), 8'h01);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk(8'({sensor_enable, irq}), 8'h00);
		acc(1'b0, 8'hd2, 8'h00);
		acc(1'b0, 8'h10, 8'h00);
		acc(1'b0, 8'hca, 8'h00);
		$display("reset end");
		give_verdict();
	end
endmodule
